// ### rtl/nvm_regs.svh
// register offsets, field positions, reset values and timing for the nvm access block
`ifndef NVM_REGS_SVH
`define NVM_REGS_SVH

`define NVM_OFF_CONTROL   12'h000
`define NVM_OFF_UNLOCK    12'h004
`define NVM_OFF_DATA_LO   12'h008
`define NVM_OFF_DATA_HI   12'h00c
`define NVM_OFF_ADDR_LO   12'h010
`define NVM_OFF_ADDR_HI   12'h014
`define NVM_OFF_PFLAGS2   12'h018

`define NVM_CTL_READ      0
`define NVM_CTL_WRITE     1
`define NVM_CTL_PERMIT    2
`define NVM_CTL_ABORT     3
`define NVM_CTL_SPACE     7
`define NVM_PF2_DONE      4

`define NVM_BYTE_RST      8'h00
`define NVM_KEY_FIRST     8'h55
`define NVM_KEY_SECOND    8'haa
`define NVM_ERASED_BYTE   8'hff

`define NVM_DATA_DEPTH    256
`define NVM_PROG_DEPTH    8192
`define NVM_PROG_WIDTH    14

`define NVM_WRITE_TIME_NS 4000000
`define NVM_CLK_PERIOD_NS 40

`endif

// ### rtl/nvm_pkg.sv
// types shared by the nvm access block
package nvm_pkg;
  typedef logic [11:0] nvm_paddr_t;
  typedef logic [31:0] nvm_word_t;
  typedef enum logic [2:0] {
    UL_IDLE  = 3'b001,
    UL_FIRST = 3'b010,
    UL_ARMED = 3'b100
  } nvm_unlock_e;
  typedef enum logic [2:0] {
    WS_IDLE  = 3'b001,
    WS_ERASE = 3'b010,
    WS_PROG  = 3'b100
  } nvm_wstate_e;
endpackage

// ### rtl/nvm_store.sv
// nonvolatile store array with erase and program strobes
`timescale 1ns/10ps
`default_nettype none
module nvm_store #(
  parameter int W     = 8,
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic          clk,     // core clock
  input  wire logic          ce,      // clock enable
  input  wire logic          erase,   // erase addressed location
  input  wire logic          prog,    // program addressed location
  input  wire logic [AW-1:0] addr,    // location
  input  wire logic [W-1:0]  wdata,   // value to program
  output logic      [W-1:0]  rdata    // current content
);
  initial begin
    if (DEPTH > (1 << AW) || W < 1) $error("nvm_store: bad geometry");
  end

  logic [W-1:0] mem [DEPTH];

  // no reset: contents survive every reset
  always_ff @(posedge clk) begin
    if (ce && erase) begin
      mem[addr] <= '1;
    end else if (ce && prog) begin
      mem[addr] <= wdata;
    end
  end

  assign rdata = mem[addr];
endmodule
`default_nettype wire

// ### rtl/nvm_cycle_timer.sv
// one-shot cycle timer with a done pulse
`timescale 1ns/10ps
`default_nettype none
module nvm_cycle_timer #(
  parameter int LEN = 4
) (
  input  wire logic clk,     // core clock
  input  wire logic ce,      // clock enable
  input  wire logic clr,     // synchronous abort
  input  wire logic start,   // begin interval
  output logic      done     // one cycle at interval end
);
  localparam int CW = $clog2(LEN + 1);
  initial begin
    if (LEN < 2) $error("nvm_cycle_timer: LEN too small");
  end

  logic [CW-1:0] cnt;

  always_ff @(posedge clk) begin
    if (clr) begin
      cnt  <= '0;
      done <= 1'b0;
    end else if (ce) begin
      done <= (cnt == CW'(1));
      if (start) begin
        cnt <= CW'(LEN);
      end else if (cnt != '0) begin
        cnt <= cnt - CW'(1);
      end
    end
  end
endmodule
`default_nettype wire

// ### rtl/nvm_indirect_access_ctrl.sv
// indirect read/write control for the data and program stores, apb register slave
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "nvm_regs.svh"
module nvm_indirect_access_ctrl #(
  parameter int WRITE_CYCLES =
    (`NVM_WRITE_TIME_NS + `NVM_CLK_PERIOD_NS - 1) / `NVM_CLK_PERIOD_NS
) (
  input  wire logic               CORE_CLK_I,     // 25 MHz core clock
  input  wire logic               RESET_N_I,      // power-up reset, sync, low
  input  wire logic               CE_I,           // clock enable
  input  wire logic               EXT_RESET_N_I,  // external reset pin, low
  input  wire logic               WDT_RESET_I,    // watchdog timeout, same clock
  input  wire logic               PSEL_I,         // apb select
  input  wire logic               PENABLE_I,      // apb enable
  input  wire logic               PWRITE_I,       // apb direction
  input  wire nvm_pkg::nvm_paddr_t PADDR_I,       // apb byte address
  input  wire nvm_pkg::nvm_word_t  PWDATA_I,      // apb write data
  output nvm_pkg::nvm_word_t       PRDATA_O,      // apb read data
  output logic                     PREADY_O,      // apb ready
  output logic                     PSLVERR_O      // apb unmapped address
);
  import nvm_pkg::*;

  localparam int HALF = WRITE_CYCLES / 2;
  initial begin
    if (WRITE_CYCLES < 4) $error("WRITE_CYCLES must be at least 4");
  end

  logic [7:0]  data_low;
  logic [7:0]  data_high;
  logic [7:0]  addr_low;
  logic [7:0]  addr_high;
  logic        space_select;
  logic        write_permit;
  logic        write_abort_flag;
  logic        write_done_flag;
  logic        rd_bit;
  logic        wr_bit;
  logic [1:0]  rd_cnt;
  logic        ext_meta_n;
  logic        ext_sync_n;
  nvm_unlock_e unlock_state;
  nvm_wstate_e wstate;
  logic [7:0]  dmem_rdata;
  logic [13:0] pmem_rdata;
  logic        phase_done;
  logic        erase_go;
  logic        prog_go;

  // the pin passes two flops; only the second is looked at
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      ext_meta_n <= 1'b1;
      ext_sync_n <= 1'b1;
    end else if (CE_I) begin
      ext_meta_n <= EXT_RESET_N_I;
      ext_sync_n <= ext_meta_n;
    end
  end

  wire other_rst = !ext_sync_n || WDT_RESET_I;

  // apb decode; register writes are ignored while the core sits in reset
  wire acc     = PSEL_I && PENABLE_I && PREADY_O && !other_rst;
  wire apb_wr  = acc && PWRITE_I;
  wire wr_ctl  = apb_wr && (PADDR_I == `NVM_OFF_CONTROL);
  wire wr_unl  = apb_wr && (PADDR_I == `NVM_OFF_UNLOCK);
  wire w_busy  = (wstate != WS_IDLE);
  wire hold    = rd_bit || w_busy;
  wire rd_go   = wr_ctl && PWDATA_I[`NVM_CTL_READ] && !hold;
  wire start_ok = wr_ctl && PWDATA_I[`NVM_CTL_WRITE] && !hold
                  && write_permit && (unlock_state == UL_ARMED);
  wire wr_finish = (wstate == WS_PROG) && phase_done;

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= '0;
    end else if (CE_I) begin
      // zero wait: ready rises in the first access cycle
      PREADY_O  <= PSEL_I && !PENABLE_I;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= '0;
      if (PSEL_I && !PENABLE_I) begin
        case (PADDR_I)
          `NVM_OFF_CONTROL: begin
            PRDATA_O[`NVM_CTL_SPACE]  <= space_select;
            PRDATA_O[`NVM_CTL_ABORT]  <= write_abort_flag;
            PRDATA_O[`NVM_CTL_PERMIT] <= write_permit;
            PRDATA_O[`NVM_CTL_WRITE]  <= wr_bit;
            PRDATA_O[`NVM_CTL_READ]   <= rd_bit;
          end
          `NVM_OFF_UNLOCK:  PRDATA_O <= '0;
          `NVM_OFF_DATA_LO: PRDATA_O[7:0] <= data_low;
          `NVM_OFF_DATA_HI: PRDATA_O[7:0] <= data_high;
          `NVM_OFF_ADDR_LO: PRDATA_O[7:0] <= addr_low;
          `NVM_OFF_ADDR_HI: PRDATA_O[7:0] <= addr_high;
          `NVM_OFF_PFLAGS2: PRDATA_O[`NVM_PF2_DONE] <= write_done_flag;
          default:          PSLVERR_O <= 1'b1;
        endcase
      end
    end
  end

  // unlock key sequence; any other register write breaks it
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I || (CE_I && other_rst)) begin
      unlock_state <= UL_IDLE;
    end else if (CE_I && apb_wr) begin
      case (unlock_state)
        UL_IDLE:
          unlock_state <= (wr_unl && PWDATA_I[7:0] == `NVM_KEY_FIRST) ? UL_FIRST : UL_IDLE;
        UL_FIRST:
          unlock_state <= (wr_unl && PWDATA_I[7:0] == `NVM_KEY_SECOND) ? UL_ARMED : UL_IDLE;
        UL_ARMED:
          unlock_state <= UL_IDLE;
        default:
          unlock_state <= UL_IDLE;
      endcase
    end
  end

  // address and data holding; untouched by the external and watchdog resets
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      addr_low  <= `NVM_BYTE_RST;
      addr_high <= `NVM_BYTE_RST;
      data_low  <= `NVM_BYTE_RST;
      data_high <= `NVM_BYTE_RST;
    end else if (CE_I) begin
      if (apb_wr && !w_busy && PADDR_I == `NVM_OFF_ADDR_LO) begin
        addr_low <= PWDATA_I[7:0];
      end
      if (apb_wr && !w_busy && PADDR_I == `NVM_OFF_ADDR_HI) begin
        addr_high <= PWDATA_I[7:0];
      end
      if (rd_bit && rd_cnt == 2'd1) begin
        if (space_select) begin
          data_low  <= pmem_rdata[7:0];
          data_high <= {2'b00, pmem_rdata[13:8]};
        end else begin
          data_low <= dmem_rdata;
        end
      end else if (apb_wr && !w_busy) begin
        if (PADDR_I == `NVM_OFF_DATA_LO) data_low <= PWDATA_I[7:0];
        if (PADDR_I == `NVM_OFF_DATA_HI) data_high <= PWDATA_I[7:0];
      end
    end
  end

  // control bits: start bits only set by software, cleared by hardware
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      space_select <= 1'b0;
      write_permit <= 1'b0;
      rd_bit       <= 1'b0;
      rd_cnt       <= 2'd0;
    end else if (CE_I) begin
      if (other_rst) begin
        write_permit <= 1'b0;
        rd_bit       <= 1'b0;
        rd_cnt       <= 2'd0;
      end else begin
        if (wr_ctl) begin
          write_permit <= PWDATA_I[`NVM_CTL_PERMIT];
          if (!hold) space_select <= PWDATA_I[`NVM_CTL_SPACE];
        end
        if (rd_go) begin
          rd_bit <= 1'b1;
          // program reads take one extra cycle for the fetch
          rd_cnt <= PWDATA_I[`NVM_CTL_SPACE] ? 2'd2 : 2'd1;
        end else if (rd_bit) begin
          rd_cnt <= rd_cnt - 2'd1;
          if (rd_cnt == 2'd1) rd_bit <= 1'b0;
        end
      end
    end
  end

  // write cycle: erase half, then program half
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I || (CE_I && other_rst)) begin
      wstate <= WS_IDLE;
      wr_bit <= 1'b0;
    end else if (CE_I) begin
      case (wstate)
        WS_IDLE: begin
          if (start_ok) begin
            wstate <= WS_ERASE;
            wr_bit <= 1'b1;
          end
        end
        WS_ERASE: begin
          if (phase_done) wstate <= WS_PROG;
        end
        WS_PROG: begin
          if (phase_done) begin
            wstate <= WS_IDLE;
            wr_bit <= 1'b0;
          end
        end
        default: begin
          wstate <= WS_IDLE;
          wr_bit <= 1'b0;
        end
      endcase
    end
  end

  // sticky flags; a hardware set beats a software clear in the same cycle
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      write_abort_flag <= 1'b0;
      write_done_flag  <= 1'b0;
    end else if (CE_I) begin
      if (other_rst && w_busy) begin
        write_abort_flag <= 1'b1;
      end else if (wr_ctl) begin
        write_abort_flag <= PWDATA_I[`NVM_CTL_ABORT];
      end
      if (wr_finish) begin
        write_done_flag <= 1'b1;
      end else if (apb_wr && PADDR_I == `NVM_OFF_PFLAGS2) begin
        write_done_flag <= PWDATA_I[`NVM_PF2_DONE];
      end
    end
  end

  assign erase_go = (wstate == WS_ERASE) && phase_done && CE_I;
  assign prog_go  = wr_finish && CE_I;

  nvm_cycle_timer #(.LEN(HALF)) u_timer (
    .clk   (CORE_CLK_I),
    .ce    (CE_I),
    .clr   (!RESET_N_I || (CE_I && other_rst)),
    .start (start_ok || erase_go),
    .done  (phase_done)
  );

  // upper address bits beyond the store are dropped; software keeps them clear
  nvm_store #(.W(8), .DEPTH(`NVM_DATA_DEPTH), .AW(8)) u_data_store (
    .clk   (CORE_CLK_I),
    .ce    (CE_I),
    .erase (erase_go && !space_select),
    .prog  (prog_go && !space_select),
    .addr  (addr_low),
    .wdata (data_low),
    .rdata (dmem_rdata)
  );

  nvm_store #(.W(`NVM_PROG_WIDTH), .DEPTH(`NVM_PROG_DEPTH), .AW(13)) u_prog_store (
    .clk   (CORE_CLK_I),
    .ce    (CE_I),
    .erase (erase_go && space_select),
    .prog  (prog_go && space_select),
    .addr  ({addr_high[4:0], addr_low}),
    .wdata ({data_high[5:0], data_low}),
    .rdata (pmem_rdata)
  );

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESET_N_I || !CE_I);
  sequence s_start;
    !wr_bit ##1 wr_bit;
  endsequence
  sequence s_prog_fetch;
    rd_bit ##1 rd_bit ##1 !rd_bit;  // fetch cycle, then the word is loaded
  endsequence

  property p_data_read;
    (rd_go && !PWDATA_I[`NVM_CTL_SPACE]) |=> rd_bit ##1 !rd_bit && data_low == $past(dmem_rdata);
  endproperty
  a_data_read: assert property (p_data_read) else $error("data read late or wrong");

  property p_prog_read;
    (rd_go && PWDATA_I[`NVM_CTL_SPACE] && !other_rst) |=> s_prog_fetch
      ##0 ({data_high[5:0], data_low} == $past(pmem_rdata, 1));
  endproperty
  a_prog_read: assert property (p_prog_read) else $error("program read timing wrong");

  property p_wr_permit;
    s_start |-> $past(write_permit, 1);
  endproperty
  a_wr_permit: assert property (p_wr_permit) else $error("write without permit");

  property p_wr_unlock;
    s_start |-> ($past(unlock_state, 1) == UL_ARMED);
  endproperty
  a_wr_unlock: assert property (p_wr_unlock) else $error("write without unlock");

  property p_wr_held;
    (wr_bit && !wr_finish && !other_rst) |=> wr_bit;
  endproperty
  a_wr_held: assert property (p_wr_held) else $error("write start dropped early");

  property p_wr_done;
    wr_finish && !other_rst |=> write_done_flag && !wr_bit;
  endproperty
  a_wr_done: assert property (p_wr_done) else $error("done flag not set");

  property p_abort;
    (other_rst && w_busy) |=> write_abort_flag && !wr_bit && (wstate == WS_IDLE);
  endproperty
  a_abort: assert property (p_abort) else $error("abort flag not set");

  property p_keep;
    other_rst |=> $stable(addr_low) && $stable(addr_high) && $stable(data_high)
      && $stable(space_select);
  endproperty
  a_keep: assert property (p_keep) else $error("registers lost on reset");

  property p_unlock_zero;
    (PSEL_I && !PENABLE_I && PADDR_I == `NVM_OFF_UNLOCK) |=> (PRDATA_O == '0) && PREADY_O;
  endproperty
  a_unlock_zero: assert property (p_unlock_zero) else $error("unlock port read nonzero");
endmodule
`default_nettype wire

// ### bench/nvm_host_model.sv
// apb host model standing in for the processor core
`timescale 1ns/10ps
`default_nettype none
module nvm_host_model (
  input  wire logic                clk_i,      // core clock
  output logic                     psel_o,     // apb select
  output logic                     penable_o,  // apb enable
  output logic                     pwrite_o,   // apb direction
  output nvm_pkg::nvm_paddr_t      paddr_o,    // apb byte address
  output nvm_pkg::nvm_word_t       pwdata_o,   // apb write data
  input  wire nvm_pkg::nvm_word_t  prdata_i,   // apb read data
  input  wire logic                pready_i,   // apb ready
  input  wire logic                pslverr_i   // apb error
);
  import nvm_pkg::*;
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = '0;
    pwdata_o = '0;
  end
  // request held until pready is sampled; bounded so a dead slave cannot hang the run
  task automatic xfer(input logic w, input nvm_paddr_t a, input nvm_word_t d,
                      output nvm_word_t q, output logic err, output logic ok);
    int n;
    @(posedge clk_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    ok = 1'b0;
    for (n = 0; n < 16 && !ok; n++) begin
      @(posedge clk_i);
      ok = (pready_i === 1'b1);
    end
    q = prdata_i;
    err = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### bench/nvm_indirect_access_ctrl_bench.sv
// self-checking bench for the nvm indirect access block
`timescale 1ns/10ps
`default_nettype none
`include "nvm_regs.svh"
module nvm_indirect_access_ctrl_bench;
  import nvm_pkg::*;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       ext_n = 1'b1;
  logic       wdt = 1'b0;
  logic       psel, penable, pwrite, pready, pslverr;
  nvm_paddr_t paddr;
  nvm_word_t  pwdata, prdata;
  int         mismatches = 0;
  int         n_tests = 0;

  always #20 clk = ~clk;

  // short write interval keeps the run brief
  nvm_indirect_access_ctrl #(.WRITE_CYCLES(8)) nvm_indirect_access_ctrl_i (
    .CORE_CLK_I(clk), .RESET_N_I(rst_n), .CE_I(1'b1), .EXT_RESET_N_I(ext_n),
    .WDT_RESET_I(wdt), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr));

  nvm_host_model nvm_host_model_i (
    .clk_i(clk), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready),
    .pslverr_i(pslverr));

  task automatic final_report();
    $display("mismatches %0d comparisons %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input nvm_word_t exp, input nvm_word_t got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic acc(input logic w, input nvm_paddr_t a, input nvm_word_t d,
                     output nvm_word_t q, output logic e);
    logic ok;
    nvm_host_model_i.xfer(w, a, d, q, e, ok);
    if (!ok) begin
      mismatches++;
      $display("CHECK FAILED pready expected 1 seen 0");
      final_report();
    end
  endtask

  task automatic wr(input nvm_paddr_t a, input nvm_word_t d);
    nvm_word_t q;
    logic      e;
    acc(1'b1, a, d, q, e);
  endtask

  task automatic rd(input string what, input nvm_paddr_t a, input nvm_word_t exp);
    nvm_word_t q;
    logic      e;
    acc(1'b0, a, '0, q, e);
    chk(what, exp, q);
  endtask

  // both keys must be the two writes right before the start
  task automatic go(input nvm_word_t c);
    wr(`NVM_OFF_UNLOCK, 32'h55);
    wr(`NVM_OFF_UNLOCK, 32'haa);
    wr(`NVM_OFF_CONTROL, c);
  endtask

  task automatic wait_idle();
    int        n;
    nvm_word_t q;
    logic      e;
    q = 32'h2;
    for (n = 0; n < 40 && q[1] !== 1'b0; n++) acc(1'b0, `NVM_OFF_CONTROL, '0, q, e);
    if (q[1] !== 1'b0) begin
      mismatches++;
      $display("CHECK FAILED write busy expected 0 seen 1");
      final_report();
    end
  endtask

  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    $display("CHECK FAILED run length expected end seen timeout");
    final_report();
  end

  initial begin
    int        k;
    nvm_word_t q;
    logic      e;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd("control at reset", `NVM_OFF_CONTROL, 32'h0);
    wr(`NVM_OFF_UNLOCK, 32'h55);
    rd("unlock port", `NVM_OFF_UNLOCK, 32'h0);
    acc(1'b0, 12'h01c, '0, q, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    wr(`NVM_OFF_ADDR_HI, 32'h3f);
    wr(`NVM_OFF_ADDR_LO, 32'hff);
    wr(`NVM_OFF_DATA_LO, 32'ha5);
    wr(`NVM_OFF_CONTROL, 32'h04);
    go(32'h06);
    rd("write start held", `NVM_OFF_CONTROL, 32'h06);
    wr(`NVM_OFF_CONTROL, 32'h04);
    rd("write start kept", `NVM_OFF_CONTROL, 32'h06);
    wait_idle();
    rd("done flag set", `NVM_OFF_PFLAGS2, 32'h10);
    wr(`NVM_OFF_PFLAGS2, 32'h0);
    rd("done flag clear", `NVM_OFF_PFLAGS2, 32'h0);
    wr(`NVM_OFF_DATA_LO, 32'h0);
    wr(`NVM_OFF_CONTROL, 32'h01);
    rd("data byte read", `NVM_OFF_DATA_LO, 32'ha5);
    wr(`NVM_OFF_CONTROL, 32'h0);
    go(32'h06);
    rd("permit same access", `NVM_OFF_CONTROL, 32'h04);
    wr(`NVM_OFF_UNLOCK, 32'h55);
    wr(`NVM_OFF_DATA_LO, 32'h5a);
    wr(`NVM_OFF_UNLOCK, 32'haa);
    wr(`NVM_OFF_CONTROL, 32'h06);
    rd("broken unlock", `NVM_OFF_CONTROL, 32'h04);
    wr(`NVM_OFF_ADDR_HI, 32'h1f);
    wr(`NVM_OFF_ADDR_LO, 32'hff);
    wr(`NVM_OFF_DATA_HI, 32'h3f);
    wr(`NVM_OFF_DATA_LO, 32'h77);
    wr(`NVM_OFF_CONTROL, 32'h84);
    go(32'h86);
    wait_idle();
    wr(`NVM_OFF_DATA_LO, 32'h0);
    wr(`NVM_OFF_DATA_HI, 32'h0);
    wr(`NVM_OFF_CONTROL, 32'h81);
    // the slot right after a program read start is spent on the fetch
    @(posedge clk);
    rd("word low", `NVM_OFF_DATA_LO, 32'h77);
    rd("word high", `NVM_OFF_DATA_HI, 32'h3f);
    wr(`NVM_OFF_CONTROL, 32'h01);
    rd("data top byte", `NVM_OFF_DATA_LO, 32'ha5);
    for (k = 0; k < 2; k++) begin
      wr(`NVM_OFF_ADDR_LO, 32'h40 + k);
      wr(`NVM_OFF_CONTROL, k ? 32'h84 : 32'h04);
      go(k ? 32'h86 : 32'h06);
      @(posedge clk);
      // the pin passes a two-stage synchroniser, so it is held three edges
      if (k == 0) wdt <= 1'b1;
      else ext_n <= 1'b0;
      repeat (3) @(posedge clk);
      wdt <= 1'b0;
      ext_n <= 1'b1;
      repeat (3) @(posedge clk);
      rd("abort flag", `NVM_OFF_CONTROL, k ? 32'h88 : 32'h08);
      rd("address kept", `NVM_OFF_ADDR_LO, 32'h40 + k);
      rd("data kept", `NVM_OFF_DATA_LO, 32'ha5);
      wr(`NVM_OFF_CONTROL, 32'h0);
    end
    final_report();
  end
endmodule
`default_nettype wire
